// File: logic/cog_regs.sv
// Channel offset and gain register bank behind an AXI4-Lite slave
// How it works
// RL1: Each colour keeps 8-bit offset, reset zero.
// RL2: Broadcast offset write sets all three offsets.
// RL3: Gain code is high part joined low bit.
// RL4: Gain high parts at indices 28h, 29h, 2Ah.
// RL5: Broadcast low-bit write sets all three low bits.
// RL6: Broadcast high-part write sets all three high parts.
// RL7: Law 0 gain is 416 over 566 minus code.
// RL8: Law 1 gain is one plus 4code/511.
// RL9: Broadcast locations hold nothing, write channels only.
`timescale 1ns/1ps
`include "cog_params.svh"

module cog_regs import cog_pkg::*; #(
	parameter int GAIN_FRAC = 12
) (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output cog_chan_t [2:0] chan_setting, // Per channel codes
	output logic gain_law_select, // Gain law in force
	output logic [2:0][15:0] channel_gain // Gain per channel
);

	cog_state_t q, d;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_en;
	logic [5:0] wr_idx;
	logic [7:0] wr_byte;
	logic wr_lane0;
	cog_dec_t wr_dec;
	cog_dec_t rd_dec;
	logic [5:0] rd_idx;

	// ==========================================================
	// Address decode, shared by the write and the read path
	function automatic cog_dec_t decode(input logic [5:0] idx);
		cog_dec_t r;
		r.kind = COG_K_BAD;
		r.chan = 2'h0;
		unique case (idx)
			`COG_IDX_OFS_RED: begin
				r.kind = COG_K_OFS;
				r.chan = 2'h0;
			end
			`COG_IDX_OFS_GRN: begin
				r.kind = COG_K_OFS;
				r.chan = 2'h1;
			end
			`COG_IDX_OFS_BLU: begin
				r.kind = COG_K_OFS;
				r.chan = 2'h2;
			end
			`COG_IDX_OFS_ALL: begin
				r.kind = COG_K_OFS;
				r.chan = 2'h3;
			end
			`COG_IDX_GLO_RED: begin
				r.kind = COG_K_GLO;
				r.chan = 2'h0;
			end
			`COG_IDX_GLO_GRN: begin
				r.kind = COG_K_GLO;
				r.chan = 2'h1;
			end
			`COG_IDX_GLO_BLU: begin
				r.kind = COG_K_GLO;
				r.chan = 2'h2;
			end
			`COG_IDX_GLO_ALL: begin
				r.kind = COG_K_GLO;
				r.chan = 2'h3;
			end
			`COG_IDX_GHI_RED: begin // see RL4
				r.kind = COG_K_GHI;
				r.chan = 2'h0;
			end
			`COG_IDX_GHI_GRN: begin // see RL4
				r.kind = COG_K_GHI;
				r.chan = 2'h1;
			end
			`COG_IDX_GHI_BLU: begin // see RL4
				r.kind = COG_K_GHI;
				r.chan = 2'h2;
			end
			`COG_IDX_GHI_ALL: begin
				r.kind = COG_K_GHI;
				r.chan = 2'h3;
			end
			`COG_IDX_LAW: begin
				r.kind = COG_K_LAW;
			end
			default: begin
				r.kind = COG_K_BAD;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// Handshakes; gated by ce so nothing is taken while frozen
	assign s_axi_awready = ce && !q.aw_full && !q.bvalid;
	assign s_axi_wready = ce && !q.w_full && !q.bvalid;
	assign s_axi_arready = ce && !q.rvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// Write operands come from the holding slot or straight off
	// the bus, so address and data may arrive in either order
	assign wr_idx = q.aw_full ? q.aw_idx : s_axi_awaddr[7:2];
	assign wr_byte = q.w_full ? q.w_byte : s_axi_wdata[7:0];
	assign wr_lane0 = q.w_full ? q.w_lane0 : s_axi_wstrb[0];
	assign wr_en = ce && !q.bvalid && (q.aw_full || aw_take)
		&& (q.w_full || w_take);
	assign wr_dec = decode(wr_idx);
	assign rd_idx = s_axi_araddr[7:2];
	assign rd_dec = decode(rd_idx);

	// ==========================================================
	// Next state of the whole bank
	always_comb begin
		d = q;
		// Park an early half of a write until the other arrives
		if (aw_take) begin
			d.aw_full = 1'b1;
			d.aw_idx = s_axi_awaddr[7:2];
		end
		if (w_take) begin
			d.w_full = 1'b1;
			d.w_byte = s_axi_wdata[7:0];
			d.w_lane0 = s_axi_wstrb[0];
		end
		// Perform the write; all registers sit in byte lane 0
		if (wr_en) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `COG_RESP_OKAY;
			if (wr_dec.kind == COG_K_BAD) begin
				d.bresp = `COG_RESP_SLVERR;
			end else if (wr_lane0) begin
				for (int c = 0; c < 3; c++) begin
					// Broadcast just hits every channel; see RL9
					if (wr_dec.chan == 2'(c) || wr_dec.chan == 2'h3) begin
						unique case (wr_dec.kind)
							COG_K_OFS: begin
								d.ofs[c] = wr_byte; // see RL1, see RL2
							end
							COG_K_GLO: begin
								d.glo[c] = wr_byte[`COG_GLO_BIT]; // see RL5
							end
							COG_K_GHI: begin
								d.ghi[c] = wr_byte; // see RL4, see RL6
							end
							default: begin
							end
						endcase
					end
				end
				if (wr_dec.kind == COG_K_LAW) begin
					d.law = wr_byte[`COG_LAW_BIT];
				end
			end
		end else if (q.bvalid && s_axi_bready && ce) begin
			d.bvalid = 1'b0;
		end
		// Reads answer one cycle after the address is taken
		if (ar_take) begin
			d.rvalid = 1'b1;
			d.rresp = `COG_RESP_OKAY;
			d.rdata = 8'h00;
			unique case (rd_dec.kind)
				COG_K_OFS: begin
					if (rd_dec.chan != 2'h3) begin
						d.rdata = q.ofs[rd_dec.chan];
					end
				end
				COG_K_GLO: begin
					if (rd_dec.chan != 2'h3) begin
						d.rdata = {7'h00, q.glo[rd_dec.chan]};
					end
				end
				COG_K_GHI: begin
					if (rd_dec.chan != 2'h3) begin
						d.rdata = q.ghi[rd_dec.chan];
					end
				end
				COG_K_LAW: begin
					d.rdata = {7'h00, q.law};
				end
				COG_K_BAD: begin
					d.rresp = `COG_RESP_SLVERR;
				end
			endcase
		end else if (q.rvalid && s_axi_rready && ce) begin
			d.rvalid = 1'b0;
		end
	end

	// ==========================================================
	// State register; reset clears every code to zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ofs <= {3{`COG_RST_OFS}}; // see RL1
			q.glo <= {3{`COG_RST_GLO}}; // see RL3
			q.ghi <= {3{`COG_RST_GHI}}; // see RL3
			q.law <= `COG_RST_LAW;
			q.bresp <= `COG_RESP_OKAY;
			q.rresp <= `COG_RESP_OKAY;
		end else if (ce) begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs and per channel gain calculators
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = {24'h000000, q.rdata};
	assign gain_law_select = q.law;

	generate
		for (genvar c = 0; c < 3; c++) begin : g_chan
			// High part above the low bit forms the full code
			assign chan_setting[c].offset_code = q.ofs[c];
			assign chan_setting[c].full_gain_code =
				{q.ghi[c], q.glo[c]}; // see RL3
			cog_gain_calc #(
				.FRAC(GAIN_FRAC)
			) u_gain (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.full_gain_code(chan_setting[c].full_gain_code),
				.gain_law_select(q.law),
				.gain(channel_gain[c])
			);
		end
	endgenerate

	// ==========================================================
	// Checks on the register writes and the gain code
	a_ofs_single: assert property (@(posedge clock) disable iff (rst) // see RL1
		wr_en && wr_lane0 && wr_dec.kind == COG_K_OFS && wr_dec.chan == 2'h1
		|=> chan_setting[1].offset_code == $past(wr_byte))
		else $error("single offset write lost");
	a_ofs_bcast: assert property (@(posedge clock) disable iff (rst) // see RL2
		wr_en && wr_lane0 && wr_idx == `COG_IDX_OFS_ALL
		|=> chan_setting[0].offset_code == $past(wr_byte)
		&& chan_setting[1].offset_code == $past(wr_byte)
		&& chan_setting[2].offset_code == $past(wr_byte))
		else $error("broadcast offset not applied");
	a_code_concat: assert property (@(posedge clock) disable iff (rst) // see RL3
		wr_en && wr_lane0 && wr_idx == `COG_IDX_GLO_BLU
		|=> chan_setting[2].full_gain_code
		== {$past(q.ghi[2]), $past(wr_byte[`COG_GLO_BIT])})
		else $error("gain low bit not joined below high part");
	a_ghi_blue: assert property (@(posedge clock) disable iff (rst) // see RL4
		wr_en && wr_lane0 && wr_idx == 6'h2A
		|=> chan_setting[2].full_gain_code[8:1] == $past(wr_byte))
		else $error("blue high part not at its index");
	a_glo_bcast: assert property (@(posedge clock) disable iff (rst) // see RL5
		wr_en && wr_lane0 && wr_idx == `COG_IDX_GLO_ALL
		|=> q.glo == {3{$past(wr_byte[0])}})
		else $error("broadcast low bit not applied");
	a_ghi_bcast: assert property (@(posedge clock) disable iff (rst) // see RL6
		wr_en && wr_lane0 && wr_idx == `COG_IDX_GHI_ALL
		|=> q.ghi == {3{$past(wr_byte)}})
		else $error("broadcast high part not applied");
	a_law_zero: assert property (@(posedge clock) disable iff (rst) // see RL7
		ce && !q.law && chan_setting[0].full_gain_code == 9'h000
		&& GAIN_FRAC == 12 |=> channel_gain[0] == 16'h0BC2)
		else $error("law 0 gain wrong at zero code");
	a_law_one: assert property (@(posedge clock) disable iff (rst) // see RL8
		ce && q.law && chan_setting[1].full_gain_code == 9'h000
		&& GAIN_FRAC == 12 |=> channel_gain[1] == 16'h1000)
		else $error("law 1 gain wrong at zero code");
	a_bcast_nostore: assert property (@(posedge clock) disable iff (rst) // see RL9
		ar_take && rd_idx == `COG_IDX_GHI_ALL
		|=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
		else $error("broadcast location reads nonzero");
	a_write_answer: assert property (@(posedge clock) disable iff (rst)
		wr_en |=> s_axi_bvalid ##0 !s_axi_awready[*1])
		else $error("write answer missing");

	// ==========================================================
	// Bus answers, ignored writes and the enable freeze
	a_read_answer: assert property (@(posedge clock) disable iff (rst)
		ar_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	// Unmapped writes answer with an error and touch nothing
	a_bad_write: assert property (@(posedge clock) disable iff (rst)
		wr_en && wr_dec.kind == COG_K_BAD |=> s_axi_bresp == `COG_RESP_SLVERR
		&& $stable(chan_setting) && $stable(gain_law_select))
		else $error("unmapped write not refused");
	// Lane 0 off still answers OKAY, so a host cannot tell; codes stay
	a_lane_off: assert property (@(posedge clock) disable iff (rst)
		wr_en && !wr_lane0 && wr_dec.kind != COG_K_BAD
		|=> s_axi_bresp == `COG_RESP_OKAY
		&& $stable(chan_setting) && $stable(gain_law_select))
		else $error("write with lane 0 off changed a code");
	// The law bit sits in lane 0 like every other field
	a_law_write: assert property (@(posedge clock) disable iff (rst)
		wr_en && wr_lane0 && wr_idx == `COG_IDX_LAW
		|=> gain_law_select == $past(wr_byte[`COG_LAW_BIT]))
		else $error("gain law select not written");
	// While frozen nothing may move, answers and codes included
	a_freeze: assert property (@(posedge clock) disable iff (rst)
		!ce |=> $stable(q))
		else $error("state moved while enable was low");

	c_bcast_ofs: cover property (@(posedge clock) disable iff (rst)
		wr_en && wr_idx == `COG_IDX_OFS_ALL);
	c_split_write: cover property (@(posedge clock) disable iff (rst)
		w_take && !aw_take ##[1:4] aw_take);
	c_read_stall: cover property (@(posedge clock) disable iff (rst)
		s_axi_rvalid && !s_axi_rready ##1 s_axi_rvalid && s_axi_rready);
	c_law_switch: cover property (@(posedge clock) disable iff (rst)
		$rose(q.law));
	c_freeze: cover property (@(posedge clock) disable iff (rst)
		!ce ##1 ce);

endmodule

// File: logic/cog_params.svh
// Constants of the channel offset and gain register bank
`ifndef COG_PARAMS_SVH
`define COG_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define COG_IDX_W 6
`define COG_IDX_OFS_RED 6'h20
`define COG_IDX_OFS_GRN 6'h21
`define COG_IDX_OFS_BLU 6'h22
`define COG_IDX_OFS_ALL 6'h23
`define COG_IDX_GLO_RED 6'h24
`define COG_IDX_GLO_GRN 6'h25
`define COG_IDX_GLO_BLU 6'h26
`define COG_IDX_GLO_ALL 6'h27
`define COG_IDX_GHI_RED 6'h28
`define COG_IDX_GHI_GRN 6'h29
`define COG_IDX_GHI_BLU 6'h2A
`define COG_IDX_GHI_ALL 6'h2B
`define COG_IDX_LAW 6'h2C

// ==========================================================
// Field positions and reset values
`define COG_LAW_BIT 0
`define COG_GLO_BIT 0
`define COG_RST_OFS 8'h00
`define COG_RST_GLO 1'b0
`define COG_RST_GHI 8'h00
`define COG_RST_LAW 1'b0

// ==========================================================
// Gain formula constants and bus answers
`define COG_LAW0_NUM 416
`define COG_LAW0_DEN 566
`define COG_LAW1_DIV 511
`define COG_RESP_OKAY 2'h0
`define COG_RESP_SLVERR 2'h2

`endif

// File: logic/cog_pkg.sv
// Types shared by the channel offset and gain register bank
package cog_pkg;

	// Kind of register an index selects
	typedef enum logic [2:0] {
		COG_K_OFS,
		COG_K_GLO,
		COG_K_GHI,
		COG_K_LAW,
		COG_K_BAD
	} cog_kind_t;

	// Decoded register: kind and channel, channel 3 means all
	typedef struct packed {
		cog_kind_t kind;
		logic [1:0] chan;
	} cog_dec_t;

	// Settings of one colour channel as seen by the analogue path
	typedef struct packed {
		logic [7:0] offset_code;
		logic [8:0] full_gain_code;
	} cog_chan_t;

	// Whole state of the bank
	typedef struct packed {
		logic aw_full;
		logic [5:0] aw_idx;
		logic w_full;
		logic [7:0] w_byte;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic law;
		logic [2:0][7:0] ofs;
		logic [2:0] glo;
		logic [2:0][7:0] ghi;
	} cog_state_t;

	// State of the gain calculator
	typedef struct packed {
		logic [15:0] gain;
	} cog_gain_state_t;

endpackage

// File: logic/cog_gain_calc.sv
// Gain value of one channel computed from its gain code and law
`timescale 1ns/1ps
`include "cog_params.svh"

module cog_gain_calc import cog_pkg::*; #(
	parameter int FRAC = 12
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic [8:0] full_gain_code, // Nine-bit gain code
	input wire logic gain_law_select, // Gain law choice
	output logic [15:0] gain // Gain, FRAC fraction bits
);

	cog_gain_state_t q, d;
	logic [23:0] num0;
	logic [9:0] den0;
	logic [23:0] num1;
	logic [23:0] quo;

	// ==========================================================
	// Gain formulas; division stays combinational since the code
	// only changes on register writes, trading area for simplicity
	always_comb begin
		num0 = 24'(`COG_LAW0_NUM) << FRAC;
		den0 = 10'(`COG_LAW0_DEN) - {1'b0, full_gain_code};
		num1 = {15'h0000, full_gain_code} << (FRAC + 2);
		d = q;
		if (!gain_law_select) begin
			quo = num0 / {14'h0000, den0}; // see RL7
		end else begin
			quo = (24'h000001 << FRAC)
				+ num1 / 24'(`COG_LAW1_DIV); // see RL8
		end
		d.gain = quo[15:0];
	end

	// State register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign gain = q.gain;

	// ==========================================================
	// Top code point of both laws at 12 fraction bits
	a_law0_corners: assert property (@(posedge clock) disable iff (rst)
		ce && !gain_law_select && full_gain_code == 9'h1FF
		|=> FRAC != 12 || gain == 16'h7904) // see RL7
		else $error("law 0 gain wrong at top code");
	a_law1_corners: assert property (@(posedge clock) disable iff (rst)
		ce && gain_law_select && full_gain_code == 9'h1FF
		|=> FRAC != 12 || gain == 16'h5000) // see RL8
		else $error("law 1 gain wrong at top code");

endmodule

// File: sim/cog_host.sv
// AXI4-Lite host model that drives the register bank
`timescale 1ns/1ps

module cog_host (
	input wire logic clock, // System clock
	output logic [7:0] awaddr, // Write address
	output logic awvalid, // Write address valid
	input wire logic awready, // Write address ready
	output logic [31:0] wdata, // Write data
	output logic [3:0] wstrb, // Write strobes
	output logic wvalid, // Write data valid
	input wire logic wready, // Write data ready
	input wire logic [1:0] bresp, // Write response
	input wire logic bvalid, // Write response valid
	output logic bready, // Write response ready
	output logic [7:0] araddr, // Read address
	output logic arvalid, // Read address valid
	input wire logic arready, // Read address ready
	input wire logic [31:0] rdata, // Read data
	input wire logic [1:0] rresp, // Read response
	input wire logic rvalid, // Read data valid
	output logic rready // Read data ready
);
	// Idle cycles before each request, to play a slow host
	int gap = 0;

	// ==========================================================
	// Idle bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
	end

	// One write; a released payload is inverted so stale data never match
	task automatic wr(input logic [5:0] i, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic a;
		logic w;
		repeat (gap + 1) @(posedge clock);
		awaddr <= {i, 2'h0};
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b1;
		w = 1'b1;
		while (a || w) begin
			@(posedge clock);
			if (a && awready === 1'b1) begin
				a = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~awaddr;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	// One read, result taken at the handshake edge
	task automatic rd(input logic [5:0] i, output logic [31:0] d,
		output logic [1:0] r);
		repeat (gap + 1) @(posedge clock);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~araddr;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// File: sim/channel_offset_gain_registers_tb.sv
// Self-checking testbench of the channel offset and gain register bank
`timescale 1ns/1ps
`include "cog_params.svh"

module channel_offset_gain_registers_tb import cog_pkg::*;;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, law;
	cog_chan_t [2:0] cs;
	logic [2:0][15:0] gn;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;

	// ==========================================================
	// Clock, timeout and instances
	always #20 clock = ~clock;

	// Cuts a hang short well beyond the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			final_report;
		end
	end

	cog_regs cog_regs_i (.clock(clock), .rst(rst), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .chan_setting(cs), .gain_law_select(law),
		.channel_gain(gn));

	cog_host cog_host_i (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] exp_gain(input logic [8:0] c,
		input logic l);
		int n;
		n = int'(c);
		if (l)
			return 16'(4096 + n * 16384 / 511);
		return 16'(416 * 4096 / (566 - n));
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wchk(input int i, input logic [7:0] d,
		input logic [1:0] er);
		cog_host_i.wr(6'(i), d, 4'hF, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rchk(input int i, input logic [7:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		cog_host_i.rd(6'(i), d, r);
		chk("rdata", {24'h0, e}, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int i = 32; i <= 44; i++)
			rchk(i, 8'h00, `COG_RESP_OKAY);
		chk("codes", 32'h0, {31'h0, |cs});
		chk("gain0", {16'h0, exp_gain(9'h000, 1'b0)}, {16'h0, gn[0]});
	endtask

	// Distinct values per channel expose crossed channels
	task automatic t_chan;
		for (int i = 0; i < 3; i++) begin
			wchk(`COG_IDX_OFS_RED + i, 8'(8'h31 + i), `COG_RESP_OKAY);
			wchk(`COG_IDX_GHI_RED + i, 8'(8'h80 + i), `COG_RESP_OKAY);
			wchk(`COG_IDX_GLO_RED + i, 8'(i == 1), `COG_RESP_OKAY);
		end
		for (int i = 0; i < 3; i++) begin
			chk("ofs", 32'(8'h31 + i), {24'h0, cs[i].offset_code});
			chk("code", {23'h0, 8'(8'h80 + i), i == 1},
				{23'h0, cs[i].full_gain_code});
			rchk(`COG_IDX_GHI_RED + i, 8'(8'h80 + i), `COG_RESP_OKAY);
		end
	endtask

	task automatic t_bcast;
		wchk(`COG_IDX_OFS_ALL, 8'hA5, `COG_RESP_OKAY);
		wchk(`COG_IDX_GLO_ALL, 8'h01, `COG_RESP_OKAY);
		wchk(`COG_IDX_GHI_ALL, 8'h5A, `COG_RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			chk("ofs all", 32'h0A5, {24'h0, cs[i].offset_code});
			chk("code all", 32'h0B5, {23'h0, cs[i].full_gain_code});
		end
		rchk(`COG_IDX_OFS_ALL, 8'h00, `COG_RESP_OKAY);
		rchk(`COG_IDX_OFS_BLU, 8'hA5, `COG_RESP_OKAY);
		rchk(`COG_IDX_GLO_GRN, 8'h01, `COG_RESP_OKAY);
	endtask

	// Slow host, unmapped places and a write with its lane disabled
	task automatic t_err;
		cog_host_i.gap = 3;
		wchk(6'h00, 8'h77, `COG_RESP_SLVERR);
		rchk(6'h3F, 8'h00, `COG_RESP_SLVERR);
		cog_host_i.wr(`COG_IDX_OFS_RED, 8'hEE, 4'h0, r);
		chk("strb0", {30'h0, `COG_RESP_OKAY}, {30'h0, r});
		rchk(`COG_IDX_OFS_RED, 8'hA5, `COG_RESP_OKAY);
		cog_host_i.gap = 0;
	endtask

	// Both laws at the ends of the code range and at code 0AB
	task automatic t_law;
		logic [8:0] c;
		for (int l = 0; l < 2; l++) begin
			wchk(`COG_IDX_LAW, 8'(l), `COG_RESP_OKAY);
			for (int k = 0; k < 3; k++) begin
				c = (k == 0) ? 9'h000 : (k == 1) ? 9'h0AB : 9'h1FF;
				wchk(`COG_IDX_GLO_ALL, {7'h0, c[0]}, `COG_RESP_OKAY);
				wchk(`COG_IDX_GHI_ALL, c[8:1], `COG_RESP_OKAY);
				repeat (3) @(negedge clock);
				chk("law", 32'(l), {31'h0, law});
				for (int i = 0; i < 3; i++)
					chk("gain", {16'h0, exp_gain(c, l[0])}, {16'h0, gn[i]});
			end
		end
	endtask

	// A low enable must hold every ready down
	task automatic t_ce;
		@(posedge clock);
		ce <= 1'b0;
		@(negedge clock);
		chk("readies", 32'h0, {29'h0, awready, wready, arready});
		@(posedge clock);
		ce <= 1'b1;
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(negedge clock);
		t_reset;
		t_chan;
		t_bcast;
		t_err;
		t_law;
		t_ce;
		final_report;
	end
endmodule
